// *** ps_cfg_pkg.sv ***
`default_nettype none
package ps_cfg_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CNT_W = 16;
  // power-on hold of the status line, least time
  localparam int POR_DELAY_NS = 1000;
  localparam int POR_CYCLES = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYCLES - 1);
  // host pulse width on the reconfiguration request, least time
  localparam int RECONFIG_LOW_NS = 2000;
  localparam int RECONFIG_LOW_CYCLES = (RECONFIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] RECONFIG_LOW_LAST = CNT_W'(RECONFIG_LOW_CYCLES - 1);
  // host-made link clock: half period in system cycles
  localparam int LINK_HALF_CYCLES = 6;
  localparam logic [CNT_W-1:0] LINK_HALF_LAST = CNT_W'(LINK_HALF_CYCLES - 1);
  // bitstream length in bits, a multiple of 8, sent lsb first per byte
  localparam int BITSTREAM_BITS = 64;
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BITSTREAM_BITS - 1);
  localparam logic [CNT_W-1:0] INIT_DONE_OPT_POS = 16'h0008;
  localparam logic [1:0] TRAIL_FALLS = 2'h2;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  // build-time choice: data pin becomes a user i/o after configuration
  localparam logic DATA_PIN_USER_IO = 1'b1;

  // value counts once the second and third stage agree
  function automatic logic agree_filt(input logic s2, input logic s3, input logic held);
    return (s2 == s3) ? s3 : held;
  endfunction
endpackage
`default_nettype wire

// *** ps_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ps_cfg_if;
  logic reconfig_request_n;
  logic serial_load_clock;
  logic host_data;
  logic host_data_oe;
  logic dev_data;
  logic dev_data_oe;
  logic status_pull_low;
  logic done_pull_low;
  logic init_done_pull_low;
  logic config_status_line;
  logic load_complete;
  logic init_done;
  logic serial_load_in;

  // open-drain lines with pull-ups
  assign config_status_line = ~status_pull_low;
  assign load_complete = ~done_pull_low;
  assign init_done = ~init_done_pull_low;
  assign serial_load_in = host_data_oe ? host_data : (dev_data_oe ? dev_data : 1'b1);

  modport device(
    input reconfig_request_n,
    input serial_load_clock,
    input serial_load_in,
    output status_pull_low,
    output done_pull_low,
    output init_done_pull_low,
    output dev_data,
    output dev_data_oe
  );
  modport host(
    output reconfig_request_n,
    output serial_load_clock,
    output host_data,
    output host_data_oe,
    input config_status_line,
    input load_complete,
    input init_done,
    input serial_load_in
  );
endinterface
`default_nettype wire

// *** ps_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module ps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] COUNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = count_r != COUNT_FULL;
  assign out_valid_o = count_r != '0;
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PTR_LAST) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PTR_LAST) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** ps_cfg_device.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - user mode: request, status, complete all high
// - request low abandons user mode, restarts configuration
// - status held low through power-on delay
// - complete held low until all data taken
// - serial clock ignored once configuration completes
// - host keeps serial clock at defined level
// - data pin becomes user i/o afterwards
// - host sends the whole bitstream
// - complete released only after every bit
// - two falling edges after complete start initialization
// - init-done low from option bit until initialization
module ps_cfg_device
  import ps_cfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  ps_cfg_if.device link,
  output logic [7:0] cfg_data_o,
  output logic cfg_valid_o,
  input wire logic cfg_ready_i,
  output logic user_mode_o,
  output logic config_error_o,
  input wire logic user_io_out_i,
  input wire logic user_io_oe_i,
  output logic user_io_in_o
);
  typedef enum logic [2:0] {
    D_POR,
    D_HOLD,
    D_LOAD,
    D_TRAIL,
    D_USER,
    D_ERROR
  } dev_state_t;

  dev_state_t state_r;
  dev_state_t state_nxt;

  // three-stage sampling of request, clock and data
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;
  logic clk_prev_r;
  logic req_n;
  logic lclk;
  logic ldata;
  logic rise;
  logic fall;

  logic [CNT_W-1:0] por_cnt_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [1:0] fall_cnt_r;
  logic init_en_r;
  logic user_io_in_r;

  logic push;
  logic [7:0] push_byte;
  logic fifo_ready;
  logic last_bit;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // pin idle levels: request high, clock and data low, so no false edge
      sync1_r <= 3'h1;
      sync2_r <= 3'h1;
      sync3_r <= 3'h1;
      filt_r <= 3'h1;
      clk_prev_r <= 1'b0;
    end else begin
      sync1_r <= {link.serial_load_in, link.serial_load_clock, link.reconfig_request_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 3; i++) begin
        filt_r[i] <= agree_filt(sync2_r[i], sync3_r[i], filt_r[i]);
      end
      clk_prev_r <= filt_r[1];
    end
  end

  assign req_n = filt_r[0];
  assign lclk = filt_r[1];
  assign ldata = filt_r[2];
  assign rise = lclk & ~clk_prev_r;
  assign fall = ~lclk & clk_prev_r;

  // one bit per rising edge while loading
  assign last_bit = bit_cnt_r == BIT_LAST;
  assign push_byte = {ldata, shift_r[7:1]};
  assign push = (state_r == D_LOAD) && rise && (bit_cnt_r[2:0] == 3'h7);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      D_POR: begin
        // no data accepted before the power-on delay ends
        if (por_cnt_r == POR_LAST) begin
          state_nxt = req_n ? D_LOAD : D_HOLD;
        end
      end
      D_HOLD: begin
        if (req_n) begin
          state_nxt = D_LOAD;
        end
      end
      D_LOAD: begin
        if (!req_n) begin
          state_nxt = D_HOLD;
        end else if (push && !fifo_ready) begin
          // bytes cannot be lost silently: overrun is a load error
          state_nxt = D_ERROR;
        end else if (rise && last_bit) begin
          state_nxt = D_TRAIL;
        end
      end
      D_TRAIL: begin
        if (!req_n) begin
          state_nxt = D_HOLD;
        end else if (fall && (fall_cnt_r == TRAIL_FALLS - 2'h1)) begin
          state_nxt = D_USER;
        end
      end
      D_USER: begin
        // only the request is watched here; clock edges do nothing
        if (!req_n) begin
          state_nxt = D_HOLD;
        end
      end
      D_ERROR: begin
        if (!req_n) begin
          state_nxt = D_HOLD;
        end
      end
      default: begin
        state_nxt = D_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= D_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_cnt_r <= '0;
    end else if (state_r == D_POR) begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_r <= '0;
      shift_r <= 8'h00;
    end else if (state_r != D_LOAD) begin
      bit_cnt_r <= '0;
    end else if (rise) begin
      shift_r <= push_byte;
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fall_cnt_r <= 2'h0;
    end else if (state_r != D_TRAIL) begin
      fall_cnt_r <= 2'h0;
    end else if (fall) begin
      fall_cnt_r <= fall_cnt_r + 2'h1;
    end
  end

  // option bit enables the init-done output for this load
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      init_en_r <= 1'b0;
    end else if (state_r == D_HOLD || state_r == D_POR) begin
      init_en_r <= 1'b0;
    end else if (state_r == D_LOAD && rise && bit_cnt_r == INIT_DONE_OPT_POS) begin
      init_en_r <= ldata;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      user_io_in_r <= 1'b0;
    end else begin
      user_io_in_r <= (state_r == D_USER) ? ldata : 1'b0;
    end
  end

  ps_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) ps_fifo_i (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_data_i(push_byte),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .out_data_o(cfg_data_o),
    .out_valid_o(cfg_valid_o),
    .out_ready_i(cfg_ready_i)
  );

  // status low during power-on, request hold and after an error
  assign link.status_pull_low = (state_r == D_POR) || (state_r == D_HOLD) ||
                                (state_r == D_ERROR);
  // complete stays low until the final bit is
  assign link.done_pull_low = (state_r != D_TRAIL) && (state_r != D_USER);
  // all three lines high in user mode; status and complete already in D_TRAIL
  assign user_mode_o = state_r == D_USER;
  assign link.init_done_pull_low = init_en_r && (state_r == D_LOAD || state_r == D_TRAIL);
  // data pin handed to user logic after configuration
  assign link.dev_data_oe = DATA_PIN_USER_IO && (state_r == D_USER) && user_io_oe_i;
  assign link.dev_data = user_io_out_i;
  assign user_io_in_o = user_io_in_r;
  assign config_error_o = state_r == D_ERROR;
endmodule
`default_nettype wire

// *** ps_cfg_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_host
  import ps_cfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  ps_cfg_if.host link,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  output logic busy_o,
  output logic done_o,
  output logic error_o
);
  typedef enum logic [3:0] {
    H_IDLE,
    H_REQ_LOW,
    H_WAIT_STATUS,
    H_LOW,
    H_HIGH,
    H_WAIT_DONE,
    H_TRAIL_LOW,
    H_TRAIL_HIGH,
    H_FINISH
  } host_state_t;

  host_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [1:0] fall_cnt_r;
  logic req_n_r;
  logic clk_r;
  logic data_r;
  logic data_oe_r;
  logic done_r;
  logic error_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;
  logic [1:0] filt_r;
  logic status_ok;
  logic complete;
  logic half_end;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      sync3_r <= 2'h0;
      filt_r <= 2'h0;
    end else begin
      sync1_r <= {link.load_complete, link.config_status_line};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 2; i++) begin
        filt_r[i] <= agree_filt(sync2_r[i], sync3_r[i], filt_r[i]);
      end
    end
  end

  assign status_ok = filt_r[0];
  assign complete = filt_r[1];
  assign half_end = cnt_r == LINK_HALF_LAST;
  // byte consumed when its last bit's high phase ends
  assign byte_ready_o = (state_r == H_HIGH) && half_end && (bit_cnt_r[2:0] == 3'h7);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      bit_cnt_r <= '0;
      fall_cnt_r <= 2'h0;
      req_n_r <= 1'b1;
      clk_r <= 1'b0;
      data_r <= 1'b0;
      data_oe_r <= 1'b1;
      done_r <= 1'b0;
      error_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      case (state_r)
        H_IDLE, H_FINISH: begin
          cnt_r <= '0;
          if (start_i) begin
            state_r <= H_REQ_LOW;
            req_n_r <= 1'b0;
            data_oe_r <= 1'b1;
            done_r <= 1'b0;
            error_r <= 1'b0;
          end
        end
        H_REQ_LOW: begin
          if (cnt_r == RECONFIG_LOW_LAST) begin
            req_n_r <= 1'b1;
            state_r <= H_WAIT_STATUS;
          end
        end
        H_WAIT_STATUS: begin
          cnt_r <= '0;
          bit_cnt_r <= '0;
          if (status_ok) begin
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          // stall with the clock low while no byte is offered
          if (cnt_r == '0 && !byte_valid_i) begin
            cnt_r <= '0;
          end else if (cnt_r == '0) begin
            data_r <= byte_i[bit_cnt_r[2:0]];
          end else if (half_end) begin
            cnt_r <= '0;
            clk_r <= 1'b1;
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            cnt_r <= '0;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == BIT_LAST) begin
              state_r <= H_WAIT_DONE;
            end else begin
              clk_r <= 1'b0;
              state_r <= H_LOW;
            end
          end
        end
        H_WAIT_DONE: begin
          cnt_r <= '0;
          fall_cnt_r <= 2'h0;
          if (complete) begin
            clk_r <= 1'b0;
            state_r <= H_TRAIL_LOW;
          end
        end
        H_TRAIL_LOW: begin
          if (half_end) begin
            cnt_r <= '0;
            if (fall_cnt_r == TRAIL_FALLS - 2'h1) begin
              // clock parked low, never left undriven
              data_oe_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= H_FINISH;
            end else begin
              fall_cnt_r <= fall_cnt_r + 2'h1;
              clk_r <= 1'b1;
              state_r <= H_TRAIL_HIGH;
            end
          end
        end
        H_TRAIL_HIGH: begin
          if (half_end) begin
            cnt_r <= '0;
            clk_r <= 1'b0;
            state_r <= H_TRAIL_LOW;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
      // device pulled status low mid-load: abandon, clock parked low
      if ((state_r == H_LOW || state_r == H_HIGH || state_r == H_WAIT_DONE) && !status_ok) begin
        state_r <= H_IDLE;
        clk_r <= 1'b0;
        error_r <= 1'b1;
      end
    end
  end

  assign link.reconfig_request_n = req_n_r;
  assign link.serial_load_clock = clk_r;
  assign link.host_data = data_r;
  assign link.host_data_oe = data_oe_r;
  assign busy_o = (state_r != H_IDLE) && (state_r != H_FINISH);
  assign done_o = done_r;
  assign error_o = error_r;
endmodule
`default_nettype wire

// *** ps_cfg_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_checker (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic reconfig_request_n,
  input wire logic serial_load_clock,
  input wire logic config_status_line,
  input wire logic load_complete,
  input wire logic init_done,
  input wire logic dev_data_oe
);
  logic [7:0] por_cnt_r;
  logic clk_q_r;
  logic [6:0] rise_cnt_r;
  logic [1:0] fall_cnt_r;
  wire logic rise = serial_load_clock & ~clk_q_r;
  wire logic fall = ~serial_load_clock & clk_q_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // saturates, so power-up hold is only judged once
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_cnt_r <= 8'h00;
    end else if (por_cnt_r != 8'hff) begin
      por_cnt_r <= por_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_q_r <= 1'b0;
    end else begin
      clk_q_r <= serial_load_clock;
    end
  end

  // raw pin edges; device sees them a few cycles later
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rise_cnt_r <= 7'h00;
      fall_cnt_r <= 2'h0;
    end else begin
      if (!config_status_line) begin
        rise_cnt_r <= 7'h00;
      end else if (rise && rise_cnt_r != 7'h7f) begin
        rise_cnt_r <= rise_cnt_r + 7'h01;
      end
      if (!load_complete) begin
        fall_cnt_r <= 2'h0;
      end else if (fall && fall_cnt_r != 2'h3) begin
        fall_cnt_r <= fall_cnt_r + 2'h1;
      end
    end
  end

  sequence s_req_low;
    !reconfig_request_n ##1 !reconfig_request_n;
  endsequence

  a_por_status_hold: assert property (por_cnt_r < 8'hbe |-> !config_status_line)
    else $error("status released during power-up hold");
  a_complete_needs_status: assert property (!config_status_line |-> !load_complete)
    else $error("complete high while status low");
  a_request_restarts: assert property (s_req_low |-> ##[1:8] !config_status_line)
    else $error("request low did not pull status low");
  a_complete_levels: assert property (
    $rose(load_complete) |-> config_status_line && reconfig_request_n)
    else $error("complete rose without status and request high");
  a_complete_all_bits: assert property ($rose(load_complete) |-> rise_cnt_r == 7'h40)
    else $error("complete rose before all bits");
  a_complete_stays: assert property (
    load_complete && reconfig_request_n |=> load_complete)
    else $error("complete dropped without request");
  a_init_fall_bit: assert property (
    $fell(init_done) |-> !load_complete && rise_cnt_r == 7'h09)
    else $error("init done fell away from option bit");
  a_init_rise_user: assert property (
    $rose(init_done) |-> !config_status_line || fall_cnt_r == 2'h2)
    else $error("init done released before two falls");
  a_user_io_after: assert property (
    $rose(dev_data_oe) |-> load_complete && fall_cnt_r == 2'h2)
    else $error("data pin driven before user mode");
endmodule
`default_nettype wire

// *** passive_serial_config_load_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module passive_serial_config_load_tb_top;
  import ps_cfg_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  logic byte_valid_i = 1'b0;
  logic cfg_ready_i = 1'b0;
  logic drain_en = 1'b0;
  logic user_io_out_i = 1'b0;
  logic user_io_oe_i = 1'b0;
  logic [7:0] byte_i = 8'h00;
  logic byte_ready_o, busy_o, done_o, error_o, user_mode_o, config_error_o;
  logic user_io_in_o, cfg_valid_o;
  logic [7:0] cfg_data_o;
  logic [7:0] stream [8] = '{8'ha5, 8'h01, 8'h3c, 8'hf0, 8'h5a, 8'h81, 8'h7e, 8'hc3};
  logic [7:0] got_q [$];
  logic [2:0] cyc = 3'h0;
  int errors = 0;
  int n_compared = 0;

  ps_cfg_if ps_cfg_if_i ();
  ps_cfg_host ps_cfg_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(ps_cfg_if_i),
    .start_i(start_i), .byte_i(byte_i), .byte_valid_i(byte_valid_i),
    .byte_ready_o(byte_ready_o), .busy_o(busy_o), .done_o(done_o), .error_o(error_o));
  ps_cfg_device ps_cfg_device_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .link(ps_cfg_if_i), .cfg_data_o(cfg_data_o), .cfg_valid_o(cfg_valid_o),
    .cfg_ready_i(cfg_ready_i), .user_mode_o(user_mode_o), .config_error_o(config_error_o),
    .user_io_out_i(user_io_out_i), .user_io_oe_i(user_io_oe_i), .user_io_in_o(user_io_in_o));
  ps_cfg_checker ps_cfg_checker_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reconfig_request_n(ps_cfg_if_i.reconfig_request_n),
    .serial_load_clock(ps_cfg_if_i.serial_load_clock),
    .config_status_line(ps_cfg_if_i.config_status_line),
    .load_complete(ps_cfg_if_i.load_complete), .init_done(ps_cfg_if_i.init_done),
    .dev_data_oe(ps_cfg_if_i.dev_data_oe));

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // drain side stalls half the time to keep the fifo partly full
  always @(posedge sys_clk_i) begin
    if (cfg_valid_o === 1'b1 && cfg_ready_i === 1'b1) begin
      got_q.push_back(cfg_data_o);
    end
    #1;
    cyc = cyc + 3'h1;
    cfg_ready_i = drain_en & cyc[2];
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic hang_check(input int k);
    if (k >= 3000) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic run_load(input logic opt, input int gap, input logic ok);
    int k;
    stream[1] = {7'h00, opt};
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    tick(20);
    check_bit(user_mode_o, 1'b0, "user mode kept");
    check_bit(busy_o, 1'b1, "busy in load");
    check_bit(ps_cfg_if_i.config_status_line, 1'b0, "status not held");
    for (int b = 0; b < 8 && error_o !== 1'b1; b++) begin
      byte_i = stream[b];
      byte_valid_i = 1'b1;
      k = 0;
      do begin
        @(negedge sys_clk_i);
        k++;
      end while (byte_ready_o !== 1'b1 && error_o !== 1'b1 && k < 3000);
      hang_check(k);
      tick(1);
      if (b == 1) check_bit(ps_cfg_if_i.init_done, ~opt, "init done");
      if (b == 2 && gap > 0) begin
        byte_valid_i = 1'b0;
        tick(gap);
        check_bit(ps_cfg_if_i.serial_load_clock, 1'b0, "clock in stall");
      end
    end
    byte_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && error_o !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    hang_check(k);
    tick(10);
    check_bit(done_o, ok, "done");
    check_bit(error_o, ~ok, "host error");
    check_bit(config_error_o, ~ok, "device error");
    check_bit(ps_cfg_if_i.config_status_line, ok, "status");
    check_bit(ps_cfg_if_i.load_complete, ok, "complete");
    check_bit(user_mode_o, ok, "user mode");
    check_bit(ps_cfg_if_i.init_done, 1'b1, "init done end");
    if (ok) begin
      check_byte(8'(got_q.size()), 8'h08, "byte count");
      for (int b = 0; b < 8 && b < got_q.size(); b++) begin
        check_byte(got_q[b], stream[b], "byte");
      end
    end
  endtask

  initial begin
    tick(4);
    reset_i = 1'b0;
    tick(2);
    check_bit(ps_cfg_if_i.config_status_line, 1'b0, "por status");
    check_bit(ps_cfg_if_i.load_complete, 1'b0, "por complete");
    check_bit(busy_o, 1'b0, "busy");
    tick(150);
    check_bit(ps_cfg_if_i.config_status_line, 1'b0, "por late");
    drain_en = 1'b1;
    run_load(1'b1, 20, 1'b1);
    user_io_oe_i = 1'b1;
    tick(8);
    check_bit(ps_cfg_if_i.serial_load_in, 1'b0, "pin driven");
    check_bit(user_io_in_o, 1'b0, "pin read low");
    user_io_oe_i = 1'b0;
    tick(8);
    check_bit(user_io_in_o, 1'b1, "pin read high");
    // no drain: fifo fills and the fifth byte overruns
    got_q.delete();
    drain_en = 1'b0;
    run_load(1'b0, 10, 1'b0);
    check_bit(cfg_valid_o, 1'b1, "fifo held");
    drain_en = 1'b1;
    tick(40);
    check_byte(8'(got_q.size()), 8'h04, "fifo depth");
    for (int b = 0; b < 4 && b < got_q.size(); b++) begin
      check_byte(got_q[b], stream[b], "fifo byte");
    end
    check_bit(cfg_valid_o, 1'b0, "fifo empty");
    got_q.delete();
    run_load(1'b0, 0, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
